// >>> sar_adc_params.svh
// Purpose: Register map, field positions, reset values and timing of the SAR converter control
// Assumes: 32-bit APB data, every register field lives in the low byte
// Notes: Definitions only
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_RESULT 12'h008
`define OFS_IRQ_STATUS 12'h00c
`define OFS_IRQ_MASK 12'h010
`define CTRL0_ENABLE_BIT 0
`define CTRL0_GO_BIT 1
`define CTRL0_CHAN_LSB 2
`define CTRL0_CHAN_MSB 5
`define CTRL1_REF_LSB 0
`define CTRL1_REF_MSB 1
`define CTRL1_CLK_LSB 4
`define CTRL1_CLK_MSB 6
`define IRQ_DONE_BIT 0
`define RESET_CHAN 4'h0
`define RESET_REF 2'h0
`define RESET_CLK 3'h0
`define CHAN_FIXED_REF 4'hf
`define BITP_PER_CONV 4'ha
`define SYS_CLK_NS 40
`define RC_BITP_TYP_NS 1600
`define RC_BITP_MIN_NS 1000
`define RC_BITP_MAX_NS 6000
`define RC_BITP_CYCLES ((`RC_BITP_TYP_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define RC_MIN_CYCLES ((`RC_BITP_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define RC_MAX_CYCLES (`RC_BITP_MAX_NS / `SYS_CLK_NS)
`endif

// >>> sar_adc_pkg.sv
// Purpose: Types shared by the SAR converter control files
// Assumes: 8-bit result
// Notes: Analog controls travel as one packed struct
`default_nettype none
package sar_adc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_FINISH} seq_state_t;
	typedef struct packed {
		logic power;
		logic sample;
		logic [2:0] ref_onehot;
		logic ch_valid;
		logic [3:0] channel;
		logic [7:0] trial;
	} analog_ctrl_t;
endpackage
`default_nettype wire

// >>> conv_tick_gen.sv
// Purpose: Conversion clock tick, one pulse per bit period
// Assumes: clk_sel codes as in the control register
// Notes: RC timer runs free, untouched by the divider selection
`default_nettype none
`include "sar_adc_params.svh"
module conv_tick_gen #(
	parameter int RC_CYCLES = `RC_BITP_CYCLES
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] clk_sel,
	output logic tick
);
	localparam int RCW = $clog2(RC_CYCLES + 1);
	localparam logic [RCW-1:0] RC_LAST = RCW'(RC_CYCLES - 1);
	logic [5:0] div_reg;
	logic [RCW-1:0] rc_reg;
	generate
		if (RC_CYCLES < `RC_MIN_CYCLES || RC_CYCLES > `RC_MAX_CYCLES)
		begin : g_bad_rc
			$error("RC bit period outside its allowed range");
		end
	endgenerate
	function automatic logic div_tick(input logic [2:0] sel, input logic [5:0] cnt);
		logic [2:0] shift;
		logic [5:0] mask;
		shift = 3'd1 + {sel[1:0], 1'b0} + {2'b00, sel[2]};
		mask = 6'h3f >> (3'd6 - shift);
		return (cnt & mask) == mask;
	endfunction
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			div_reg <= 6'h00;
		else
			div_reg <= div_reg + 6'h01;
	end
	always_ff @(posedge sys_clk)
	begin
		if (rst || rc_reg == RC_LAST)
			rc_reg <= '0;
		else
			rc_reg <= rc_reg + 1'b1;
	end
	always_comb
	begin
		if (clk_sel[1:0] == 2'b11)
			tick = (rc_reg == RC_LAST);
		else
			tick = div_tick(clk_sel, div_reg);
	end
endmodule
`default_nettype wire

// >>> sar_core.sv
// Purpose: Successive approximation register
// Assumes: comp_high is high when the held input is at or above the trial code
// Notes: fill gives the partial result with undecided bits copying the last decided one
`default_nettype none
module sar_core #(
	parameter int WIDTH = 8
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic init,
	input wire logic step,
	input wire logic comp_high,
	output logic [WIDTH-1:0] trial,
	output logic [WIDTH-1:0] fill
);
	logic [WIDTH-1:0] value_reg;
	logic [WIDTH-1:0] ptr_reg;
	logic [WIDTH-1:0] low;
	logic last;
	generate
		if (WIDTH < 2)
		begin : g_bad_width
			$error("SAR width must be at least two");
		end
	endgenerate
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			value_reg <= '0;
			ptr_reg <= '0;
		end
		else if (init)
		begin
			value_reg <= '0;
			ptr_reg <= {1'b1, {(WIDTH-1){1'b0}}};
		end
		else if (step)
		begin
			if (comp_high)
				value_reg <= value_reg | ptr_reg;
			ptr_reg <= ptr_reg >> 1;
		end
	end
	assign trial = value_reg | ptr_reg;
	always_comb
	begin
		low = ptr_reg | (ptr_reg - 1'b1);
		last = |(value_reg & {ptr_reg[WIDTH-2:0], 1'b0});
		if (ptr_reg == '0 || !last)
			fill = value_reg;
		else
			fill = value_reg | low;
	end
endmodule
`default_nettype wire

// >>> sar_adc_control.sv
// Purpose: Control of an 8-bit SAR converter behind an APB slave
// Assumes: Analog mux, sample-and-hold, DAC and comparator sit outside
// Notes: One wait state on every APB access
`default_nettype none
`include "sar_adc_params.svh"
module sar_adc_control #(
	parameter int RC_CYCLES = `RC_BITP_CYCLES
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic comp_high,
	input wire logic sleep_active,
	output sar_adc_pkg::analog_ctrl_t analog_out,
	output logic irq,
	output logic wake
);
	localparam int RES_W = $bits(analog_out.trial);

	logic enable_reg;
	logic [3:0] chan_sel_reg;
	logic [1:0] ref_reg;
	logic [2:0] clk_sel_reg;
	logic [RES_W-1:0] result_reg;
	logic status_reg;
	logic status_next;
	logic mask_reg;
	sar_adc_pkg::seq_state_t state_reg;
	logic [3:0] tick_cnt_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	sar_adc_pkg::analog_ctrl_t analog_reg;
	sar_adc_pkg::analog_ctrl_t analog_next;
	logic irq_reg;
	logic wake_reg;

	logic apb_access;
	logic apb_commit;
	logic wr_lane0;
	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_status;
	logic wr_mask;
	logic busy;
	logic rc_sel;
	logic start;
	logic abort;
	logic tick;
	logic complete;
	logic sar_init;
	logic sar_step;
	logic [RES_W-1:0] sar_trial;
	logic [RES_W-1:0] sar_fill;
	logic power_on;

	function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] ofs);
		return addr[11:2] == ofs[11:2];
	endfunction

	function automatic logic addr_mapped(input logic [11:0] addr);
		return addr_is(addr, `OFS_CTRL0) || addr_is(addr, `OFS_CTRL1) ||
			addr_is(addr, `OFS_RESULT) || addr_is(addr, `OFS_IRQ_STATUS) ||
			addr_is(addr, `OFS_IRQ_MASK);
	endfunction

	function automatic logic chan_code_valid(input logic [3:0] code);
		return (code <= 4'h4) || (code >= 4'h8 && code <= 4'hd) || (code == `CHAN_FIXED_REF);
	endfunction

	function automatic logic [2:0] ref_onehot(input logic [1:0] code);
		logic [2:0] sel;
		sel = 3'b001;
		if (code == 2'b10)
			sel = 3'b010;
		else if (code == 2'b11)
			sel = 3'b100;
		return sel;
	endfunction

	// APB: access phase takes one wait state, write commits at the pready edge
	assign apb_access = psel && penable && !pready_reg;
	assign apb_commit = psel && penable && pready_reg;
	assign wr_lane0 = apb_commit && pwrite && pstrb[0];
	assign wr_ctrl0 = wr_lane0 && addr_is(paddr, `OFS_CTRL0);
	assign wr_ctrl1 = wr_lane0 && addr_is(paddr, `OFS_CTRL1);
	assign wr_status = wr_lane0 && addr_is(paddr, `OFS_IRQ_STATUS);
	assign wr_mask = wr_lane0 && addr_is(paddr, `OFS_IRQ_MASK);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= apb_access;
			pslverr_reg <= apb_access && !addr_mapped(paddr);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			prdata_reg <= 32'h00000000;
		else if (apb_access && !pwrite)
		begin
			prdata_reg <= 32'h00000000;
			if (addr_is(paddr, `OFS_CTRL0))
			begin
				prdata_reg[`CTRL0_ENABLE_BIT] <= enable_reg;
				prdata_reg[`CTRL0_GO_BIT] <= busy;
				prdata_reg[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB] <= chan_sel_reg;
			end
			else if (addr_is(paddr, `OFS_CTRL1))
			begin
				prdata_reg[`CTRL1_CLK_MSB:`CTRL1_CLK_LSB] <= clk_sel_reg;
				prdata_reg[`CTRL1_REF_MSB:`CTRL1_REF_LSB] <= ref_reg;
			end
			else if (addr_is(paddr, `OFS_RESULT))
				prdata_reg[RES_W-1:0] <= result_reg;
			else if (addr_is(paddr, `OFS_IRQ_STATUS))
				prdata_reg[`IRQ_DONE_BIT] <= status_reg;
			else if (addr_is(paddr, `OFS_IRQ_MASK))
				prdata_reg[`IRQ_DONE_BIT] <= mask_reg;
		end
	end

	// Control registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			enable_reg <= 1'b0;
			chan_sel_reg <= `RESET_CHAN;
		end
		else if (wr_ctrl0)
		begin
			enable_reg <= pwdata[`CTRL0_ENABLE_BIT];
			chan_sel_reg <= pwdata[`CTRL0_CHAN_MSB:`CTRL0_CHAN_LSB];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ref_reg <= `RESET_REF;
			clk_sel_reg <= `RESET_CLK;
		end
		else if (wr_ctrl1)
		begin
			ref_reg <= pwdata[`CTRL1_REF_MSB:`CTRL1_REF_LSB];
			clk_sel_reg <= pwdata[`CTRL1_CLK_MSB:`CTRL1_CLK_LSB];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			mask_reg <= 1'b0;
		else if (wr_mask)
			mask_reg <= pwdata[`IRQ_DONE_BIT];
	end

	// Sequencer
	assign busy = (state_reg != sar_adc_pkg::ST_IDLE);
	assign rc_sel = (clk_sel_reg[1:0] == 2'b11);
	// Go is honoured only once the converter was already enabled
	assign start = wr_ctrl0 && pwdata[`CTRL0_GO_BIT] && enable_reg && !busy;
	// Clearing go or enable, or Sleep on a divided clock, cuts a conversion short
	assign abort = busy && ((wr_ctrl0 && (!pwdata[`CTRL0_GO_BIT] || !pwdata[`CTRL0_ENABLE_BIT])) ||
		(sleep_active && !rc_sel));
	assign complete = (state_reg == sar_adc_pkg::ST_FINISH) && tick && !abort;
	assign sar_init = (state_reg == sar_adc_pkg::ST_SAMPLE) && tick && !abort;
	assign sar_step = (state_reg == sar_adc_pkg::ST_CONVERT) && tick && !abort;

	conv_tick_gen #(
		.RC_CYCLES(RC_CYCLES)
	) u_tick (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_sel(clk_sel_reg),
		.tick(tick)
	);

	sar_core #(
		.WIDTH(RES_W)
	) u_sar (
		.sys_clk(sys_clk),
		.rst(rst),
		.init(sar_init),
		.step(sar_step),
		.comp_high(comp_high),
		.trial(sar_trial),
		.fill(sar_fill)
	);

	// Counts ticks from the sample tick on; the tenth one ends the conversion
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tick_cnt_reg <= 4'h0;
		else if (start)
			tick_cnt_reg <= 4'h0;
		else if (busy && tick)
			tick_cnt_reg <= tick_cnt_reg + 4'h1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst || abort)
			state_reg <= sar_adc_pkg::ST_IDLE;
		else
		begin
			case (state_reg)
				sar_adc_pkg::ST_IDLE:
					if (start)
						state_reg <= sar_adc_pkg::ST_SAMPLE;
				sar_adc_pkg::ST_SAMPLE:
					if (tick)
						state_reg <= sar_adc_pkg::ST_CONVERT;
				sar_adc_pkg::ST_CONVERT:
					if (tick && tick_cnt_reg == `BITP_PER_CONV - 4'h2)
						state_reg <= sar_adc_pkg::ST_FINISH;
				sar_adc_pkg::ST_FINISH:
					if (tick)
						state_reg <= sar_adc_pkg::ST_IDLE;
				default:
					state_reg <= sar_adc_pkg::ST_IDLE;
			endcase
		end
	end

	// Result on completion, partial result on an abort after the sample phase
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			result_reg <= '0;
		else if (complete || (abort && state_reg != sar_adc_pkg::ST_SAMPLE))
			result_reg <= sar_fill;
	end

	// Done flag: a completion in the clearing cycle wins over the clear
	always_comb
	begin
		status_next = status_reg;
		if (wr_status && pwdata[`IRQ_DONE_BIT])
			status_next = 1'b0;
		if (complete)
			status_next = 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			status_reg <= 1'b0;
		else
			status_reg <= status_next;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= status_next && mask_reg;
			wake_reg <= status_next && mask_reg && sleep_active;
		end
	end

	// Analog front end; in Sleep the converter stays up only on the RC clock,
	// and only until the end of a conversion when the interrupt is masked
	assign power_on = enable_reg && !(sleep_active && (!rc_sel || (!busy && !mask_reg)));

	always_comb
	begin
		analog_next.power = power_on;
		analog_next.sample = power_on && (state_reg == sar_adc_pkg::ST_IDLE ||
			state_reg == sar_adc_pkg::ST_SAMPLE);
		analog_next.ref_onehot = ref_onehot(ref_reg);
		analog_next.ch_valid = chan_code_valid(chan_sel_reg);
		analog_next.channel = chan_sel_reg;
		// Trial only while bits are decided on a powered front end, never a stale result
		analog_next.trial = (power_on && state_reg == sar_adc_pkg::ST_CONVERT) ? sar_trial : '0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			analog_reg <= '0;
		else
			analog_reg <= analog_next;
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign analog_out = analog_reg;
	assign irq = irq_reg;
	assign wake = wake_reg;
endmodule
`default_nettype wire

// >>> sar_adc_ctl_asserts.sv
// Purpose: Port-level checks of the SAR converter control
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every converter control instance
`default_nettype none
module sar_adc_ctl_chk #(
	parameter int RC_CYCLES = 40
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire sar_adc_pkg::analog_ctrl_t analog_out,
	input wire logic irq,
	input wire logic wake
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("unmapped read not refused");
	chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_wake_irq: assert property (wake |-> irq)
		else $error("wake without interrupt");
	chk_ref_onehot: assert property (!$past(rst) |-> analog_out.ref_onehot inside {3'h1, 3'h2, 3'h4})
		else $error("reference select not one-hot");
	chk_chan_valid: assert property (!$past(rst) |->
		analog_out.ch_valid == (analog_out.channel inside {[4'h0:4'h4], [4'h8:4'hd], 4'hf}))
		else $error("channel validity wrong");
	chk_first_trial: assert property (analog_out.trial != 8'h0 && $past(analog_out.trial) == 8'h0
		|-> analog_out.trial == 8'h80)
		else $error("first trial is not mid-scale");
	chk_off_idle: assert property (!analog_out.power |-> analog_out.trial == 8'h0)
		else $error("trial while powered off");
	cov_irq: cover property ($rose(irq));
	cov_wake: cover property ($rose(wake));
	cov_err: cover property (pslverr);
	cov_trial: cover property (analog_out.trial == 8'h80);
endmodule
bind sar_adc_control sar_adc_ctl_chk #(.RC_CYCLES(RC_CYCLES)) chk_inst (.sys_clk(sys_clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .analog_out(analog_out), .irq(irq), .wake(wake));
`default_nettype wire

// >>> analog_fe_model.sv
// Purpose: Mux, sample-and-hold and comparator in front of the converter
// Assumes: Channel n carries the level {n, 6}
// Notes: Hold keeps its old level when a reserved channel is chosen
`default_nettype none
module analog_fe_model (
	input wire logic sys_clk,
	input wire sar_adc_pkg::analog_ctrl_t analog_out,
	output logic comp_high
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] held = 8'h0;
	always @(posedge sys_clk)
		if (analog_out.power && analog_out.sample && analog_out.ch_valid)
			held <= {analog_out.channel, 4'h6};
	// Comparator against a ground-based trial level
	assign comp_high = analog_out.power && held >= analog_out.trial;
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the SAR converter control
// Assumes: Register map of the design header, RC bit period shortened
// Notes: APB master waits for ready, no fixed latency assumed
`default_nettype none
`include "sar_adc_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RC = 25;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sleep_active = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, comp_high, irq, wake, err;
	sar_adc_pkg::analog_ctrl_t analog_out;
	int n_fail = 0;
	int checks_done = 0;
	always #20 sys_clk = ~sys_clk;
	sar_adc_control #(.RC_CYCLES(RC)) sar_adc_control_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comp_high(comp_high), .sleep_active(sleep_active),
		.analog_out(analog_out), .irq(irq), .wake(wake));
	analog_fe_model analog_fe_model_inst (.sys_clk(sys_clk), .analog_out(analog_out), .comp_high(comp_high));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask
	task automatic wait_hi(input bit w, output int c);
		c = 0;
		do
		begin
			@(posedge sys_clk);
			c++;
		end
		while ((w ? wake : irq) !== 1'b1 && c < 2000);
	endtask
	task automatic convert(input logic [2:0] cs, input logic [3:0] ch, input int n);
		int c;
		apb(1'b1, `OFS_CTRL1, 32'({cs, 4'h3}));
		apb(1'b1, `OFS_CTRL0, 32'({ch, 2'b01}));
		repeat (8) @(posedge sys_clk);
		apb(1'b1, `OFS_CTRL0, 32'({ch, 2'b11}));
		wait_hi(1'b0, c);
		cmp(32'(c >= 9 * n + 1 && c <= 10 * n + 2), 32'h1);
		rdc(`OFS_RESULT, 32'({ch, 4'h6}));
		rdc(`OFS_CTRL0, 32'({ch, 2'b01}));
		rdc(`OFS_IRQ_STATUS, 32'h1);
		apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
		rdc(`OFS_IRQ_STATUS, 32'h0);
		cmp(32'(irq), 32'h0);
	endtask
	task automatic t_regs;
		rdc(`OFS_CTRL0, 32'h0);
		rdc(`OFS_CTRL1, 32'h0);
		rdc(`OFS_IRQ_STATUS, 32'h0);
		rdc(12'h014, 32'h0);
		cmp(32'(err), 32'h1);
		$display("test regs done");
	endtask
	task automatic t_sel;
		logic [2:0] oh[4] = '{3'h1, 3'h1, 3'h2, 3'h4};
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, `OFS_CTRL1, 32'(i));
			repeat (2) @(posedge sys_clk);
			cmp(32'(analog_out.ref_onehot), 32'(oh[i]));
		end
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b1, `OFS_CTRL0, 32'({i[3:0], 2'b01}));
			repeat (2) @(posedge sys_clk);
			cmp(32'(analog_out.ch_valid), 32'(i < 5 || (i > 7 && i < 14) || i == 15));
			cmp(32'(analog_out.channel), 32'(i));
			cmp(32'(analog_out.power), 32'h1);
			cmp(32'(analog_out.sample), 32'h1);
		end
		$display("test select done");
	endtask
	task automatic t_clocks;
		logic [2:0] cs[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
		int dv[8] = '{2, 4, 8, 16, 32, 64, RC, RC};
		logic [3:0] chn[8] = '{4'h0, 4'h4, 4'h8, 4'hd, 4'hf, 4'h1, 4'h2, 4'hc};
		apb(1'b1, `OFS_IRQ_MASK, 32'h1);
		for (int i = 0; i < 8; i++)
			convert(cs[i], chn[i], dv[i]);
		$display("test clocks done");
	endtask
	task automatic t_abort;
		int c;
		apb(1'b1, `OFS_CTRL1, 32'h60);
		apb(1'b1, `OFS_CTRL0, 32'h0d);
		apb(1'b1, `OFS_CTRL0, 32'h0f);
		repeat (200) @(posedge sys_clk);
		apb(1'b1, `OFS_CTRL0, 32'h0f);
		rdc(`OFS_CTRL0, 32'h0f);
		apb(1'b1, `OFS_CTRL0, 32'h0d);
		rdc(`OFS_CTRL0, 32'h0d);
		apb(1'b1, `OFS_CTRL0, 32'h0f);
		sleep_active <= 1'b1;
		repeat (800) @(posedge sys_clk);
		cmp(32'(analog_out.power), 32'h0);
		sleep_active <= 1'b0;
		rdc(`OFS_IRQ_STATUS, 32'h0);
		apb(1'b1, `OFS_CTRL1, 32'h30);
		apb(1'b1, `OFS_CTRL0, 32'h0f);
		sleep_active <= 1'b1;
		wait_hi(1'b1, c);
		cmp(32'(wake), 32'h1);
		sleep_active <= 1'b0;
		rdc(`OFS_RESULT, 32'h36);
		$display("test abort and sleep done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_regs;
		t_sel;
		t_clocks;
		t_abort;
		test_done;
	end
	initial
	begin
		#2400000;
		n_fail++;
		test_done;
	end
endmodule
`default_nettype wire
